//--- hdl/ldwp_write_port.sv
// Notes on behaviour
// [RULE_01] Select high loads the control word, select low loads display RAM.
// [RULE_02] A word is captured on the rising edge of the write strobe.
// [RULE_03] RAM writes take eight data bits; the eighth is the decimal point.
// [RULE_04] Power bit high runs normally; low stops scanning and blanks display.
// [RULE_05] Raw bit high drives segments from RAM bits; low decodes them.
// [RULE_06] Scheme bit high selects hexadecimal decode, low selects Code B.
// [RULE_07] Data-coming high announces a sequential eight-digit update; low announces a single-digit update.
// [RULE_08] With data-coming low, bits 0..2 form the single-digit address.
// [RULE_09] Bit 3 selects bank A high, bank B low, in decoded modes only.
// [RULE_10] Eight digit drive lines and eight segment lines including point.
// [RULE_11] Host writes a control word before any display RAM data.
// [RULE_12] Decimal points are stored apart from the banks and shown for both.
// [RULE_13] A control write with data-coming low leaves display RAM untouched.
// [RULE_14] After data-coming high, next eight RAM writes fill digits one to eight.
// [RULE_15] After data-coming low, the next RAM write lands in the addressed digit.
`timescale 1ns/1ps
`default_nettype none

module ldwp_write_port #(
	parameter int unsigned DIGIT_CYCLES = ldwp_pkg::DIGIT_CYCLES,
	parameter int unsigned BLANK_CYCLES = ldwp_pkg::BLANK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire ldwp_pkg::ldwp_data_t data_in,
	input wire logic mode_sel,
	input wire logic write_strobe,
	output var logic [7:0] digit_drive,
	output var ldwp_pkg::ldwp_seg_t segment_drive
);

	// ------------------------------------------------------------
	// Write strobe edge and routing
	// ------------------------------------------------------------
	logic wr_prev_r;
	logic wr_rise;
	logic ctrl_write;
	logic ram_req;
	logic ram_we;
	ldwp_pkg::ldwp_data_t display_control_word_r;
	ldwp_pkg::ldwp_entry_t entry_r;
	ldwp_pkg::ldwp_entry_t entry_nxt;
	logic [2:0] seq_idx_r;
	logic [2:0] single_addr_r;
	logic [2:0] wr_digit;
	logic bank_idx;
	logic [7:0] dp_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_prev_r <= 1'b0;
		end else begin
			wr_prev_r <= write_strobe;
		end
	end

	assign wr_rise = write_strobe & ~wr_prev_r; // see [RULE_02]
	assign ctrl_write = wr_rise & mode_sel; // see [RULE_01]
	assign ram_req = wr_rise & ~mode_sel; // see [RULE_01]

	// ------------------------------------------------------------
	// Control word
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			display_control_word_r <= ldwp_pkg::CTRL_RESET;
		end else if (ctrl_write) begin
			display_control_word_r <= data_in; // see [RULE_01]
		end
	end

	// Bank A maps to RAM half 0; no-decode always uses half 0
	assign bank_idx = ~display_control_word_r.data_in_raw_bit
		& ~display_control_word_r.data_in_bank_bit; // see [RULE_09]

	// ------------------------------------------------------------
	// Data entry sequencing
	// ------------------------------------------------------------
	always_comb begin
		entry_nxt = entry_r;
		if (ctrl_write) begin
			if (data_in.data_in_point_bit) begin
				entry_nxt = ldwp_pkg::ENTRY_SEQ; // see [RULE_07]
			end else begin
				entry_nxt = ldwp_pkg::ENTRY_SINGLE; // see [RULE_07]
			end
		end else if (ram_req) begin
			case (entry_r)
				ldwp_pkg::ENTRY_SEQ: begin
					if (seq_idx_r == ldwp_pkg::LAST_DIGIT) begin
						entry_nxt = ldwp_pkg::ENTRY_IDLE; // see [RULE_14]
					end
				end
				ldwp_pkg::ENTRY_SINGLE: begin
					entry_nxt = ldwp_pkg::ENTRY_IDLE; // see [RULE_15]
				end
				default: begin
					entry_nxt = ldwp_pkg::ENTRY_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			entry_r <= ldwp_pkg::ENTRY_IDLE;
		end else begin
			entry_r <= entry_nxt;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seq_idx_r <= 3'h0;
		end else if (ctrl_write) begin
			seq_idx_r <= 3'h0; // see [RULE_14]
		end else if (ram_we && entry_r == ldwp_pkg::ENTRY_SEQ) begin
			seq_idx_r <= seq_idx_r + 3'h1; // see [RULE_14]
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			single_addr_r <= 3'h0;
		end else if (ctrl_write && !data_in.data_in_point_bit) begin
			single_addr_r <= {data_in.data_in_bit2, data_in.data_in_bit1,
				data_in.data_in_bit0}; // see [RULE_08]
		end
	end

	// Control writes never reach the RAM; unsolicited data is dropped
	assign ram_we = ram_req & (entry_r != ldwp_pkg::ENTRY_IDLE); // see [RULE_13]
	assign wr_digit = (entry_r == ldwp_pkg::ENTRY_SEQ) ? seq_idx_r : single_addr_r; // see [RULE_15]

	// Decimal points live outside the banks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dp_r <= 8'h00;
		end else if (ram_we) begin
			dp_r[wr_digit] <= data_in.data_in_point_bit; // see [RULE_12]
		end
	end

	// ------------------------------------------------------------
	// Scan counters, held while powered down
	// ------------------------------------------------------------
	logic [15:0] slot_cnt_r;
	logic [2:0] scan_digit_r;
	logic [2:0] digit_d1_r;
	logic lit_d1_r;
	logic dp_d1_r;
	logic [7:0] ram_rdata;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			slot_cnt_r <= 16'h0000;
			scan_digit_r <= 3'h0;
		end else if (display_control_word_r.data_in_power_bit) begin
			if (slot_cnt_r == 16'(DIGIT_CYCLES - 1)) begin
				slot_cnt_r <= 16'h0000;
				scan_digit_r <= scan_digit_r + 3'h1;
			end else begin
				slot_cnt_r <= slot_cnt_r + 16'h0001;
			end
		end
	end

	ldwp_ram #(
		.AW(4),
		.DW(8)
	) u_ram (
		.clk(mclk),
		.rst(rst),
		.we(ram_we),
		.waddr({bank_idx, wr_digit}),
		.wdata(data_in), // see [RULE_03]
		.raddr({bank_idx, scan_digit_r}),
		.rdata(ram_rdata)
	);

	// Align digit, blanking and point with the RAM read latency
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			digit_d1_r <= 3'h0;
			lit_d1_r <= 1'b0;
			dp_d1_r <= 1'b0;
		end else begin
			digit_d1_r <= scan_digit_r;
			lit_d1_r <= slot_cnt_r >= 16'(BLANK_CYCLES);
			dp_d1_r <= dp_r[scan_digit_r]; // see [RULE_12]
		end
	end

	// ------------------------------------------------------------
	// Drive outputs
	// ------------------------------------------------------------
	logic [6:0] seg_body;
	logic show;

	always_comb begin
		if (display_control_word_r.data_in_raw_bit) begin
			seg_body = ram_rdata[6:0]; // see [RULE_05]
		end else begin
			seg_body = ldwp_pkg::ldwp_decode(ram_rdata[3:0],
				display_control_word_r.data_in_scheme_bit); // see [RULE_06]
		end
	end

	assign show = lit_d1_r & display_control_word_r.data_in_power_bit; // see [RULE_04]

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			digit_drive <= 8'h00;
			segment_drive <= '0;
		end else if (show) begin
			digit_drive <= 8'h01 << digit_d1_r; // see [RULE_10]
			segment_drive <= {dp_d1_r, seg_body}; // see [RULE_10]
		end else begin
			digit_drive <= 8'h00;
			segment_drive <= '0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_ctrl_write;
		write_strobe && !wr_prev_r && mode_sel;
	endsequence

	sequence s_ram_write;
		write_strobe && !wr_prev_r && !mode_sel;
	endsequence

	a_ctrl_load: assert property (s_ctrl_write |=> display_control_word_r == $past(data_in)) // see [RULE_01]
		else $error("control word not loaded");
	a_ram_keeps_ctrl: assert property (s_ram_write |=> $stable(display_control_word_r)) // see [RULE_01]
		else $error("RAM write changed control word");
	a_strobe_edge: assert property (ram_we |-> $rose(write_strobe)) // see [RULE_02]
		else $error("RAM write without strobe edge");
	a_ctrl_no_ram: assert property (s_ctrl_write |-> !ram_we) // see [RULE_13]
		else $error("control write reached RAM");
	a_shutdown_blank: assert property (!display_control_word_r.data_in_power_bit
		|=> digit_drive == 8'h00 && segment_drive == '0) // see [RULE_04]
		else $error("display lit in shutdown");
	a_digit_onehot: assert property ($onehot0(digit_drive)) // see [RULE_10]
		else $error("more than one digit driven");
	a_addr_latch: assert property (s_ctrl_write ##0 !data_in.data_in_point_bit
		|=> entry_r == ldwp_pkg::ENTRY_SINGLE && single_addr_r == $past(data_in[2:0])) // see [RULE_08]
		else $error("single digit address not latched");
	a_seq_start: assert property (s_ctrl_write ##0 data_in.data_in_point_bit
		|=> entry_r == ldwp_pkg::ENTRY_SEQ && seq_idx_r == 3'h0) // see [RULE_14]
		else $error("sequential update not started");
	a_seq_step: assert property (ram_we && entry_r == ldwp_pkg::ENTRY_SEQ
		|=> seq_idx_r == $past(seq_idx_r) + 3'h1) // see [RULE_14]
		else $error("sequential digit not advanced");
	a_seq_stop: assert property (ram_we && entry_r == ldwp_pkg::ENTRY_SEQ
		&& seq_idx_r == ldwp_pkg::LAST_DIGIT |=> entry_r == ldwp_pkg::ENTRY_IDLE) // see [RULE_14]
		else $error("sequential update did not stop");
	a_single_once: assert property (ram_we && entry_r == ldwp_pkg::ENTRY_SINGLE
		|=> entry_r == ldwp_pkg::ENTRY_IDLE) // see [RULE_15]
		else $error("single update not closed");
	a_point_store: assert property (ram_we |=> dp_r[$past(wr_digit)] == $past(data_in[7])) // see [RULE_12]
		else $error("decimal point not stored");
	a_raw_bank: assert property (display_control_word_r.data_in_raw_bit |-> !bank_idx) // see [RULE_09]
		else $error("bank used in raw mode");

endmodule

`default_nettype wire

//--- hdl/ldwp_pkg.sv
package ldwp_pkg;

	// ------------------------------------------------------------
	// Clock and scan timing
	// ------------------------------------------------------------
	localparam int unsigned MCLK_HZ = 40000000;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned DIGITS = 8;
	localparam int unsigned SCAN_RATE_HZ = 390;
	localparam int unsigned DIGIT_CYCLES = MCLK_HZ / (SCAN_RATE_HZ * DIGITS);
	localparam int unsigned BLANK_NS = 2000;
	localparam int unsigned BLANK_CYCLES = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Input word and control word layout
	// ------------------------------------------------------------
	typedef struct packed {
		logic data_in_point_bit;
		logic data_in_scheme_bit;
		logic data_in_raw_bit;
		logic data_in_power_bit;
		logic data_in_bank_bit;
		logic data_in_bit2;
		logic data_in_bit1;
		logic data_in_bit0;
	} ldwp_data_t;

	localparam int unsigned POS_POINT = 7;
	localparam int unsigned POS_SCHEME = 6;
	localparam int unsigned POS_RAW = 5;
	localparam int unsigned POS_POWER = 4;
	localparam int unsigned POS_BANK = 3;
	localparam int unsigned POS_ADDR_LSB = 0;
	localparam int unsigned ADDR_W = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] LAST_DIGIT = 3'h7;

	// Segment lines, a in bit 0
	typedef struct packed {
		logic point_segment;
		logic seg_g;
		logic seg_f;
		logic seg_e;
		logic seg_d;
		logic seg_c;
		logic seg_b;
		logic seg_a;
	} ldwp_seg_t;

	typedef enum logic [1:0] {
		ENTRY_IDLE,
		ENTRY_SEQ,
		ENTRY_SINGLE
	} ldwp_entry_t;

	// ------------------------------------------------------------
	// Character decode, result is {g,f,e,d,c,b,a}
	// ------------------------------------------------------------
	function automatic logic [6:0] ldwp_decode(input logic [3:0] code, input logic hex);
		logic [6:0] seg;
		seg = 7'h00;
		case (code)
			4'h0: seg = 7'h3F;
			4'h1: seg = 7'h06;
			4'h2: seg = 7'h5B;
			4'h3: seg = 7'h4F;
			4'h4: seg = 7'h66;
			4'h5: seg = 7'h6D;
			4'h6: seg = 7'h7D;
			4'h7: seg = 7'h07;
			4'h8: seg = 7'h7F;
			4'h9: seg = 7'h6F;
			4'hA: seg = hex ? 7'h77 : 7'h40;
			4'hB: seg = hex ? 7'h7C : 7'h79;
			4'hC: seg = hex ? 7'h39 : 7'h76;
			4'hD: seg = hex ? 7'h5E : 7'h38;
			4'hE: seg = hex ? 7'h79 : 7'h73;
			default: seg = hex ? 7'h71 : 7'h00;
		endcase
		return seg;
	endfunction

endpackage

//--- hdl/ldwp_ram.sv
`timescale 1ns/1ps
`default_nettype none

module ldwp_ram #(
	parameter int unsigned AW = 4,
	parameter int unsigned DW = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output var logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

`default_nettype wire

//--- hdl/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- verif/ldwp_host.sv
`timescale 1ns/1ps
`default_nettype none

module ldwp_host (
	input wire logic mclk,
	output var ldwp_pkg::ldwp_data_t data_in,
	output var logic mode_sel,
	output var logic write_strobe
);
	initial begin
		data_in = 8'h00;
		mode_sel = 1'b0;
		write_strobe = 1'b0;
	end

	// Word and select held across the sampling edge, then scrambled once released
	task automatic put(input logic ctl, input logic [7:0] word);
		@(negedge mclk);
		mode_sel = ctl;
		data_in = word;
		write_strobe = 1'b1;
		@(negedge mclk);
		write_strobe = 1'b0;
		data_in = ~word;
		mode_sel = ~ctl;
	endtask
endmodule

`default_nettype wire

//--- verif/led_display_write_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

module led_display_write_port_bench;
	logic mclk;
	logic rst;
	ldwp_pkg::ldwp_data_t data_in;
	logic mode_sel;
	logic write_strobe;
	logic [7:0] digit_drive;
	ldwp_pkg::ldwp_seg_t segment_drive;
	logic [7:0] dark;
	int failures;
	int checked;
	int k;

	ldwp_host u_ldwp_host (
		.mclk(mclk),
		.data_in(data_in),
		.mode_sel(mode_sel),
		.write_strobe(write_strobe)
	);

	ldwp_write_port #(.DIGIT_CYCLES(40), .BLANK_CYCLES(4)) u_ldwp_write_port (
		.mclk(mclk),
		.rst(rst),
		.data_in(data_in),
		.mode_sel(mode_sel),
		.write_strobe(write_strobe),
		.digit_drive(digit_drive),
		.segment_drive(segment_drive)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] pat(input int n);
		return 8'hA5 ^ 8'(n * 19);
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits for digit n to be lit, then compares the masked segment lines
	task automatic show(input int n, input logic [7:0] exp, input logic [7:0] mask);
		int t;
		t = 0;
		repeat (4) @(negedge mclk);
		while (digit_drive !== (8'h01 << n) && t < 1000) begin
			@(negedge mclk);
			t++;
		end
		if (t >= 1000) begin
			failures++;
			$display("[ERR] digit %0d scan expected lit seen dark", n);
			wrap_up();
		end else begin
			chk($sformatf("digit %0d segments", n), exp & mask, segment_drive & mask);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		failures = 0;
		checked = 0;
		rst = 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		chk("digit lines after reset", 8'h00, digit_drive);
		chk("segment lines after reset", 8'h00, segment_drive);
		u_ldwp_host.put(1'b1, 8'h00);
		u_ldwp_host.put(1'b1, 8'hB0);
		for (k = 0; k < 8; k++) begin
			u_ldwp_host.put(1'b0, pat(k));
		end
		u_ldwp_host.put(1'b0, 8'h00);
		for (k = 0; k < 8; k++) begin
			show(k, pat(k), 8'hFF);
		end
		$display("test sequential raw done");
		u_ldwp_host.put(1'b1, 8'h35);
		u_ldwp_host.put(1'b0, 8'h3C);
		u_ldwp_host.put(1'b0, 8'hFF);
		show(5, 8'h3C, 8'hFF);
		show(4, pat(4), 8'hFF);
		show(6, pat(6), 8'hFF);
		$display("test single digit done");
		u_ldwp_host.put(1'b1, 8'hD8);
		u_ldwp_host.put(1'b0, 8'h8A);
		for (k = 1; k < 8; k++) begin
			u_ldwp_host.put(1'b0, 8'h0A);
		end
		show(0, 8'hF7, 8'hFF);
		show(1, 8'h77, 8'hFF);
		u_ldwp_host.put(1'b1, 8'h18);
		show(1, 8'h40, 8'hFF);
		u_ldwp_host.put(1'b1, 8'h11);
		u_ldwp_host.put(1'b0, 8'h02);
		show(1, 8'h5B, 8'hFF);
		show(0, 8'h80, 8'h80);
		u_ldwp_host.put(1'b1, 8'h18);
		show(1, 8'h40, 8'hFF);
		show(0, 8'h80, 8'h80);
		$display("test decode and banks done");
		u_ldwp_host.put(1'b1, 8'h00);
		repeat (3) @(negedge mclk);
		dark = 8'h00;
		repeat (700) begin
			@(negedge mclk);
			dark = dark | digit_drive | segment_drive;
		end
		chk("outputs in shutdown", 8'h00, dark);
		$display("test shutdown done");
		wrap_up();
	end
endmodule

`default_nettype wire
